// [gpio_ports_c_d_e.sv]
// Purpose: Parallel I/O for ports C, D and E with peripheral pin sharing
// Assumes: Single clock aclk, synchronous active-low reset aresetn
// Notes:   Pin output enables are active low; pins are sampled via three
//          flops and a level counts once the last two flops agree
//
// The AXI4-Lite interface to the registers was decided locally.
module gpio_ports_c_d_e (
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  // AXI4-Lite slave
  input  wire logic [gpio_cde_pkg::ADDR_W-1:0]      awaddr,
  input  wire logic                                 awvalid,
  output logic                                      awready,
  input  wire logic [31:0]                          wdata,
  input  wire logic [3:0]                           wstrb,
  input  wire logic                                 wvalid,
  output logic                                      wready,
  output logic [1:0]                                bresp,
  output logic                                      bvalid,
  input  wire logic                                 bready,
  input  wire logic [gpio_cde_pkg::ADDR_W-1:0]      araddr,
  input  wire logic                                 arvalid,
  output logic                                      arready,
  output logic [31:0]                               rdata,
  output logic [1:0]                                rresp,
  output logic                                      rvalid,
  input  wire logic                                 rready,
  // Port pins
  input  wire logic [gpio_cde_pkg::PC_W-1:0]        port_c_in,
  output logic [gpio_cde_pkg::PC_W-1:0]             port_c_out,
  output logic [gpio_cde_pkg::PC_W-1:0]             port_c_oe_n,
  input  wire logic [gpio_cde_pkg::PD_W-1:0]        port_d_in,
  output logic [gpio_cde_pkg::PD_W-1:0]             port_d_out,
  output logic [gpio_cde_pkg::PD_W-1:0]             port_d_oe_n,
  input  wire logic [gpio_cde_pkg::PE_W-1:0]        port_e_in,
  output logic [gpio_cde_pkg::PE_W-1:0]             port_e_out,
  output logic [gpio_cde_pkg::PE_W-1:0]             port_e_oe_n,
  // Timer channel sharing, one select pair per channel
  input  wire logic [2*gpio_cde_pkg::PD_W-1:0]      edge_level_select,
  input  wire logic [gpio_cde_pkg::PD_W-1:0]        timer_channel_out,
  input  wire logic [gpio_cde_pkg::PD_W-1:0]        timer_channel_oe,
  output logic [gpio_cde_pkg::PD_W-1:0]             timer_channel_pin,
  // Serial interface sharing
  input  wire logic                                 serial_iface_enable,
  input  wire logic                                 serial_tx,
  output logic                                      serial_rx
);

  localparam int PC_W  = gpio_cde_pkg::PC_W;
  localparam int PD_W  = gpio_cde_pkg::PD_W;
  localparam int PE_W  = gpio_cde_pkg::PE_W;
  localparam int PIN_W = gpio_cde_pkg::PIN_W;
  localparam int AW    = gpio_cde_pkg::ADDR_W;

  // Whole state of the block
  typedef struct packed {
    logic              aw_full;          // Write address held
    logic [AW-1:0]     aw_addr;          // Held write address
    logic              w_full;           // Write data held
    logic [7:0]        w_data;           // Held low byte
    logic              w_lane;           // Low byte lane enabled
    logic              b_valid;          // Write response pending
    logic [1:0]        b_resp;           // Write response code
    logic              r_valid;          // Read data pending
    logic [7:0]        r_data;           // Read data, low byte
    logic [1:0]        r_resp;           // Read response code
    logic [PC_W-1:0]   port_c_latch;     // Not reset
    logic [PD_W-1:0]   port_d_latch;     // Not reset
    logic [PE_W-1:0]   port_e_latch;     // Not reset
    logic [PC_W-1:0]   port_c_direction;
    logic              clock_out_enable;
    logic [PD_W-1:0]   port_d_direction;
    logic [PE_W-1:0]   port_e_direction;
    logic [PIN_W-1:0]  sync_a;           // First synchroniser stage
    logic [PIN_W-1:0]  sync_b;           // Second stage
    logic [PIN_W-1:0]  sync_c;           // Third stage
    logic [PIN_W-1:0]  pin_level;        // Accepted pin levels
    logic              clk_toggle;       // Clock image for pin 2
    logic [PC_W-1:0]   c_out;
    logic [PC_W-1:0]   c_oe_n;
    logic [PD_W-1:0]   d_out;
    logic [PD_W-1:0]   d_oe_n;
    logic [PE_W-1:0]   e_out;
    logic [PE_W-1:0]   e_oe_n;
  } state_t;

  state_t st;
  state_t next_st;

  // Live ownership terms
  logic [PD_W-1:0] timer_owns;          // Timer claims port D pin
  logic            write_go;            // Both write halves present

  // Register index of a byte address
  function automatic logic [7:0] index_of(input logic [AW-1:0] a);
    index_of = 8'(a >> gpio_cde_pkg::IDX_LSB);
  endfunction : index_of

  // Read value of one register; flag marks a mapped index
  function automatic logic [8:0] read_reg(input state_t s,
                                          input logic [7:0] idx);
    logic [7:0] v;
    logic       hit;
    v   = 8'h00;
    hit = 1'b1;
    unique case (idx)
      gpio_cde_pkg::IDX_PORT_C_DATA:
      begin
        // Output pins show latch, inputs show pin
        v[PC_W-1:0] = (s.port_c_direction & s.port_c_latch)
                    | (~s.port_c_direction & s.pin_level[PC_W-1:0]);
        // Clock output hides this bit
        if (s.clock_out_enable)
          v[gpio_cde_pkg::PC_CLK_PIN] = 1'b0;
      end
      gpio_cde_pkg::IDX_PORT_D_DATA:
        // Direction picks source even when timer owns pin
        v[PD_W-1:0] = (s.port_d_direction & s.port_d_latch)
          | (~s.port_d_direction
             & s.pin_level[gpio_cde_pkg::PD_BASE +: PD_W]);
      gpio_cde_pkg::IDX_PORT_E_DATA:
        // Same selection while serial owns pins
        v[PE_W-1:0] = (s.port_e_direction & s.port_e_latch)
          | (~s.port_e_direction
             & s.pin_level[gpio_cde_pkg::PE_BASE +: PE_W]);
      gpio_cde_pkg::IDX_PORT_C_DIR:
      begin
        v[PC_W-1:0] = s.port_c_direction;
        v[gpio_cde_pkg::CLK_EN_BIT] = s.clock_out_enable;
      end
      gpio_cde_pkg::IDX_PORT_D_DIR:
        v[PD_W-1:0] = s.port_d_direction;
      gpio_cde_pkg::IDX_PORT_E_DIR:
        v[PE_W-1:0] = s.port_e_direction;
      default:
        hit = 1'b0;                      // Unmapped reads as zero
    endcase
    read_reg = {hit, v};
  endfunction : read_reg

  // Timer claims a pin when its select pair is non-zero
  genvar g;
  generate
    for (g = 0; g < PD_W; g++)
    begin : g_timer_claim
      assign timer_owns[g] = |edge_level_select[2*g +: 2];
    end
  endgenerate

  assign write_go = st.aw_full && st.w_full && !st.b_valid;

  // Next-state logic for bus, registers, synchronisers and drivers
  always_comb
  begin
    logic [8:0]      rd;
    logic [7:0]      widx;
    logic [PIN_W-1:0] pins_raw;
    rd       = 9'h000;
    widx     = 8'h00;
    pins_raw = {port_e_in, port_d_in, port_c_in};
    next_st  = st;

    // Pin synchroniser; accept a level once stages two and three agree
    next_st.sync_a = pins_raw;
    next_st.sync_b = st.sync_a;
    next_st.sync_c = st.sync_b;
    for (int i = 0; i < PIN_W; i++)
    begin
      if (st.sync_b[i] == st.sync_c[i])
        next_st.pin_level[i] = st.sync_c[i];
    end

    // Free-running clock image driven out when enabled
    next_st.clk_toggle = !st.clk_toggle;

    // Write address and data captured in either order
    if (awvalid && !st.aw_full)
    begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = awaddr;
    end
    if (wvalid && !st.w_full)
    begin
      next_st.w_full = 1'b1;
      next_st.w_data = wdata[7:0];
      next_st.w_lane = wstrb[0];
    end

    // Commit a write once both halves are present
    if (write_go)
    begin
      widx            = index_of(st.aw_addr);
      next_st.aw_full = 1'b0;
      next_st.w_full  = 1'b0;
      next_st.b_valid = 1'b1;
      next_st.b_resp  = gpio_cde_pkg::RESP_OKAY;
      unique case (widx)
        gpio_cde_pkg::IDX_PORT_C_DATA:
          if (st.w_lane)
          begin
            // Latch written whatever the direction
            next_st.port_c_latch = st.w_data[PC_W-1:0];
            // Clock output blocks writes to its bit
            if (st.clock_out_enable)
              next_st.port_c_latch[gpio_cde_pkg::PC_CLK_PIN] =
                st.port_c_latch[gpio_cde_pkg::PC_CLK_PIN];
          end
        gpio_cde_pkg::IDX_PORT_D_DATA:
          if (st.w_lane)
            next_st.port_d_latch = st.w_data[PD_W-1:0];
        gpio_cde_pkg::IDX_PORT_E_DATA:
          if (st.w_lane)
            next_st.port_e_latch = st.w_data[PE_W-1:0];
        gpio_cde_pkg::IDX_PORT_C_DIR:
          if (st.w_lane)
          begin
            next_st.port_c_direction = st.w_data[PC_W-1:0];
            next_st.clock_out_enable =
              st.w_data[gpio_cde_pkg::CLK_EN_BIT];
          end
        gpio_cde_pkg::IDX_PORT_D_DIR:
          if (st.w_lane)
            next_st.port_d_direction = st.w_data[PD_W-1:0];
        gpio_cde_pkg::IDX_PORT_E_DIR:
          if (st.w_lane)
            next_st.port_e_direction = st.w_data[PE_W-1:0];
        default:
          next_st.b_resp = gpio_cde_pkg::RESP_SLVERR;
      endcase
    end
    else if (st.b_valid && bready)
      next_st.b_valid = 1'b0;

    // Read: one cycle from address to data
    if (st.r_valid)
    begin
      if (rready)
        next_st.r_valid = 1'b0;
    end
    else if (arvalid)
    begin
      rd              = read_reg(st, index_of(araddr));
      next_st.r_valid = 1'b1;
      next_st.r_data  = rd[7:0];
      next_st.r_resp  = rd[8] ? gpio_cde_pkg::RESP_OKAY
                              : gpio_cde_pkg::RESP_SLVERR;
    end

    // Port C drivers: direction 1 drives, active-low enable
    next_st.c_out  = st.port_c_latch;
    next_st.c_oe_n = ~st.port_c_direction;
    if (st.clock_out_enable)
    begin
      // Clock image replaces pin 2 whatever its direction
      next_st.c_out[gpio_cde_pkg::PC_CLK_PIN]  = st.clk_toggle;
      next_st.c_oe_n[gpio_cde_pkg::PC_CLK_PIN] = 1'b0;
    end

    // Port D drivers; timer overrides direction when it owns a pin
    for (int i = 0; i < PD_W; i++)
    begin
      if (timer_owns[i])
      begin
        next_st.d_out[i]  = timer_channel_out[i];
        next_st.d_oe_n[i] = !timer_channel_oe[i];
      end
      else
      begin
        next_st.d_out[i]  = st.port_d_latch[i];
        next_st.d_oe_n[i] = !st.port_d_direction[i];
      end
    end

    // Port E drivers; serial takes both pins while enabled
    next_st.e_out  = st.port_e_latch;
    next_st.e_oe_n = ~st.port_e_direction;
    if (serial_iface_enable)
    begin
      // Transmit pin always driven by the serial side
      next_st.e_out[gpio_cde_pkg::PE_TX_PIN]  = serial_tx;
      next_st.e_oe_n[gpio_cde_pkg::PE_TX_PIN] = 1'b0;
      // Receive pin is input only
      next_st.e_oe_n[gpio_cde_pkg::PE_RX_PIN] = 1'b1;
    end

    // Synchronous reset; data latches keep their contents
    if (!aresetn)
    begin
      next_st.aw_full          = 1'b0;
      next_st.w_full           = 1'b0;
      next_st.b_valid          = 1'b0;
      next_st.r_valid          = 1'b0;
      next_st.port_c_direction = gpio_cde_pkg::PC_DIR_RST;
      next_st.clock_out_enable = 1'b0;
      next_st.port_d_direction = gpio_cde_pkg::PD_DIR_RST;
      next_st.port_e_direction = gpio_cde_pkg::PE_DIR_RST;
      next_st.clk_toggle       = 1'b0;
      next_st.c_oe_n           = '1;   // All pins released
      next_st.d_oe_n           = '1;
      next_st.e_oe_n           = '1;
      next_st.c_out            = '0;
      next_st.d_out            = '0;
      next_st.e_out            = '0;
      next_st.pin_level        = '0;
      next_st.sync_a           = '0;
      next_st.sync_b           = '0;
      next_st.sync_c           = '0;
      next_st.r_data           = 8'h00;
      next_st.r_resp           = gpio_cde_pkg::RESP_OKAY;
      next_st.b_resp           = gpio_cde_pkg::RESP_OKAY;
    end
  end

  // Single state register; reset is folded into the next value so the
  // data latches can ride through it untouched
  always_ff @(posedge aclk)
  begin
    st <= next_st;
  end

  // Bus handshakes
  assign awready = !st.aw_full;
  assign wready  = !st.w_full;
  assign arready = !st.r_valid;
  assign bvalid  = st.b_valid;
  assign bresp   = st.b_resp;
  assign rvalid  = st.r_valid;
  assign rresp   = st.r_resp;
  assign rdata   = {24'h00_0000, st.r_data};

  // Pin drivers, all from flops
  assign port_c_out  = st.c_out;
  assign port_c_oe_n = st.c_oe_n;
  assign port_d_out  = st.d_out;
  assign port_d_oe_n = st.d_oe_n;
  assign port_e_out  = st.e_out;
  assign port_e_oe_n = st.e_oe_n;

  // Synchronised pin levels toward the peripherals
  assign timer_channel_pin = st.pin_level[gpio_cde_pkg::PD_BASE +: PD_W];
  assign serial_rx =
    st.pin_level[gpio_cde_pkg::PE_BASE + gpio_cde_pkg::PE_RX_PIN];

endmodule : gpio_ports_c_d_e

// [gpio_cde_pkg.sv]
// Purpose: Shared constants for the port C, D and E parallel I/O block
// Assumes: AXI4-Lite with 32-bit data, one register per aligned word
// Notes:   Register indexes are word indexes; byte address is index * 4
package gpio_cde_pkg;
  // Register word indexes
  localparam logic [7:0] IDX_PORT_C_DATA = 8'h02;
  localparam logic [7:0] IDX_PORT_D_DATA = 8'h03;
  localparam logic [7:0] IDX_PORT_E_DATA = 8'h08;
  localparam logic [7:0] IDX_PORT_C_DIR  = 8'h10;
  localparam logic [7:0] IDX_PORT_D_DIR  = 8'h11;
  localparam logic [7:0] IDX_PORT_E_DIR  = 8'h12;
  // Byte address width and the two low bits that select a byte
  localparam int         ADDR_W          = 10;
  localparam int         IDX_LSB         = 2;
  // Port widths
  localparam int         PC_W            = 5;
  localparam int         PD_W            = 2;
  localparam int         PE_W            = 2;
  localparam int         PIN_W           = PC_W + PD_W + PE_W;
  // Bit positions
  localparam int         PC_CLK_PIN      = 2;  // Pin that can carry clock
  localparam int         CLK_EN_BIT      = 7;  // Enable bit in port C dir
  localparam int         PE_TX_PIN       = 0;  // Serial transmit pin
  localparam int         PE_RX_PIN       = 1;  // Serial receive pin
  localparam int         PD_BASE         = PC_W;
  localparam int         PE_BASE         = PC_W + PD_W;
  // Reset values
  localparam logic [PC_W-1:0] PC_DIR_RST = 5'h0_0;
  localparam logic [PD_W-1:0] PD_DIR_RST = 2'h0;
  localparam logic [PE_W-1:0] PE_DIR_RST = 2'h0;
  // Bus responses
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;
endpackage : gpio_cde_pkg

// [gpio_ports_c_d_e_props.sv]
// Purpose: Port-level checks for the port C, D and E parallel I/O block
// Assumes: One clock domain; sees only the block's top ports
// Notes:   Pin drivers settle one register stage after their cause
module gpio_ports_c_d_e_props (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic [1:0] bresp,
  input wire logic       bvalid,
  input wire logic       bready,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic [31:0] rdata,
  input wire logic       rvalid,
  input wire logic       rready,
  input wire logic [4:0] port_c_oe_n,
  input wire logic [1:0] port_d_in,
  input wire logic [1:0] port_d_out,
  input wire logic [1:0] port_d_oe_n,
  input wire logic [1:0] port_e_out,
  input wire logic [1:0] port_e_oe_n,
  input wire logic [3:0] edge_level_select,
  input wire logic [1:0] timer_channel_out,
  input wire logic [1:0] timer_channel_oe,
  input wire logic [1:0] timer_channel_pin,
  input wire logic       serial_iface_enable,
  input wire logic       serial_tx
);
  timeunit 1ns;
  timeprecision 1ps;
  // All checks share the bus clock and the synchronous reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_RD_NEXT: assert property (
    arvalid && arready |=> rvalid) else $error("read answer missing");
  AST_RD_HOLD: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  AST_WR_RESP: assert property (
    awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
    else $error("write response missing");
  AST_B_HOLD: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response not held");
  // Reset leaves every pin as an input, clock output included
  AST_RST_DIR: assert property (
    $rose(aresetn) |-> &port_c_oe_n && &port_d_oe_n && &port_e_oe_n)
    else $error("pin driven after reset");
  // A claimed timer pin follows the timer, not the direction bit
  AST_TMR_DRV: assert property (
    |edge_level_select[1:0] |=> port_d_oe_n[0] == !$past(timer_channel_oe[0])
    && port_d_out[0] == $past(timer_channel_out[0]))
    else $error("timer pin not driven by timer");
  AST_TX_DRV: assert property (
    serial_iface_enable |=> !port_e_oe_n[0]
    && port_e_out[0] == $past(serial_tx)) else $error("transmit pin wrong");
  AST_RX_IN: assert property (
    serial_iface_enable |=> port_e_oe_n[1]) else $error("receive pin driven");
  // A settled pin level reaches the timer's capture input
  AST_SYNC: assert property (
    $past(aresetn, 4) && port_d_in == $past(port_d_in, 1)
    && port_d_in == $past(port_d_in, 2) && port_d_in == $past(port_d_in, 3)
    && port_d_in == $past(port_d_in, 4) |-> timer_channel_pin == port_d_in)
    else $error("timer pin level stale");
endmodule : gpio_ports_c_d_e_props

// [gpio_pins_model.sv]
// Purpose: Board side of the pins: outside drivers that yield to the block
// Assumes: oe_n low means the block drives the pin
// Notes:   Undriven pins follow the outside levels set by the bench
module gpio_pins_model (
  input  wire logic [4:0] port_c_out,
  input  wire logic [4:0] port_c_oe_n,
  input  wire logic [1:0] port_d_out,
  input  wire logic [1:0] port_d_oe_n,
  input  wire logic [1:0] port_e_out,
  input  wire logic [1:0] port_e_oe_n,
  input  wire logic [4:0] ext_c,
  input  wire logic [1:0] ext_d,
  input  wire logic [1:0] ext_e,
  output logic      [4:0] port_c_in,
  output logic      [1:0] port_d_in,
  output logic      [1:0] port_e_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wire level: the block's value where it drives, else the outside one
  assign port_c_in = (port_c_out & ~port_c_oe_n) | (ext_c & port_c_oe_n);
  assign port_d_in = (port_d_out & ~port_d_oe_n) | (ext_d & port_d_oe_n);
  assign port_e_in = (port_e_out & ~port_e_oe_n) | (ext_e & port_e_oe_n);
endmodule : gpio_pins_model

// [gpio_ports_c_d_e_bench.sv]
// Purpose: Self-checking bench for the port C, D and E I/O block
// Assumes: AXI4-Lite master in tasks; pins through the board model
// Notes:   Pin inputs get six cycles to pass the synchronisers
module gpio_ports_c_d_e_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CD = gpio_cde_pkg::IDX_PORT_C_DATA;
  localparam logic [7:0] DD = gpio_cde_pkg::IDX_PORT_D_DATA;
  localparam logic [7:0] ED = gpio_cde_pkg::IDX_PORT_E_DATA;
  localparam logic [7:0] CR = gpio_cde_pkg::IDX_PORT_C_DIR;
  localparam logic [7:0] DR = gpio_cde_pkg::IDX_PORT_D_DIR;
  localparam logic [7:0] ER = gpio_cde_pkg::IDX_PORT_E_DIR;
  localparam logic [1:0] OK = gpio_cde_pkg::RESP_OKAY;
  logic        aclk, aresetn, awvalid, wvalid, bready, bvalid, awready;
  logic        wready, arvalid, arready, rvalid, rready, serial_rx;
  logic        serial_iface_enable, serial_tx, b;
  logic [9:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, edge_level_select;
  logic [1:0]  bresp, rresp, timer_channel_out, timer_channel_oe;
  logic [1:0]  timer_channel_pin, port_d_in, port_d_out, port_d_oe_n;
  logic [1:0]  port_e_in, port_e_out, port_e_oe_n, ext_d, ext_e;
  logic [4:0]  port_c_in, port_c_out, port_c_oe_n, ext_c;
  int          n_errors, samples_checked;
  gpio_ports_c_d_e dut (.*);
  gpio_pins_model pins (.*);
  // Free-running 100 MHz clock
  always #5 aclk = ~aclk;
  task automatic check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // One write; both halves offered together, each dropped once taken
  // Waits as long as the answer takes; only the watchdog ends a hang
  task automatic wr(input logic [7:0] idx, d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h00_0000, d};
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    check("bresp", bresp, er);
  endtask : wr
  // One read, compared whole: upper bits must be zero
  task automatic rdc(input logic [7:0] idx, d, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    check($sformatf("rdata %h", idx), rdata, {24'h00_0000, d});
    check("rresp", rresp, er);
  endtask : rdc
  task automatic t_reset;
    rdc(CR, 8'h00, OK);
    rdc(DR, 8'h00, OK);
    rdc(ER, 8'h00, OK);
    check("oe_n", {port_c_oe_n, port_d_oe_n, port_e_oe_n}, 9'h1ff);
    // Unmapped word: refused, reads zero
    rdc(8'hff, 8'h00, gpio_cde_pkg::RESP_SLVERR);
    wr(8'hff, 8'h55, gpio_cde_pkg::RESP_SLVERR);
    $display("test reset done");
  endtask : t_reset
  task automatic t_port_c;
    ext_c <= 5'h15;
    wr(CD, 8'h0a, OK);
    repeat (6) @(posedge aclk);
    rdc(CD, 8'h15, OK);
    wr(CR, 8'h1f, OK);
    rdc(CD, 8'h0a, OK);
    check("port_c_out", port_c_out, 5'h0a);
    check("port_c_oe_n", port_c_oe_n, 5'h00);
    wr(CR, 8'h03, OK);
    repeat (6) @(posedge aclk);
    rdc(CD, 8'h16, OK);
    // Clock out on pin 2: reads 0, latch write ignored
    wr(CR, 8'h80, OK);
    wr(CD, 8'h1f, OK);
    repeat (6) @(posedge aclk);
    rdc(CD, 8'h11, OK);
    check("clk_oe_n", port_c_oe_n[2], 1'b0);
    b = port_c_out[2];
    @(posedge aclk);
    // Logical not keeps the expected value one bit wide
    check("clk_out", port_c_out[2], !b);
    wr(CR, 8'h04, OK);
    rdc(CD, 8'h11, OK);
    wr(CR, 8'h00, OK);
    repeat (6) @(posedge aclk);
    rdc(CD, 8'h15, OK);
    $display("test port c done");
  endtask : t_port_c
  task automatic t_port_d;
    ext_d <= 2'h1;
    wr(DD, 8'h02, OK);
    repeat (6) @(posedge aclk);
    rdc(DD, 8'h01, OK);
    wr(DR, 8'h03, OK);
    rdc(DD, 8'h02, OK);
    check("port_d", {port_d_oe_n, port_d_out}, 4'h2);
    // Timer claims pin 0 while its direction bit says input
    ext_d <= 2'h2;
    timer_channel_oe <= 2'h1;
    timer_channel_out <= 2'h1;
    edge_level_select <= 4'h1;
    wr(DR, 8'h00, OK);
    repeat (6) @(posedge aclk);
    check("port_d", {port_d_oe_n, port_d_out[0]}, 3'h5);
    check("tmr_pin", timer_channel_pin, 2'h3);
    rdc(DD, 8'h03, OK);
    wr(DR, 8'h01, OK);
    rdc(DD, 8'h02, OK);
    edge_level_select <= 4'h0;
    $display("test port d done");
  endtask : t_port_d
  task automatic t_port_e;
    ext_e <= 2'h2;
    wr(ED, 8'h01, OK);
    repeat (6) @(posedge aclk);
    rdc(ED, 8'h02, OK);
    wr(ER, 8'h03, OK);
    rdc(ED, 8'h01, OK);
    check("port_e", {port_e_oe_n, port_e_out}, 4'h1);
    // Serial owns both pins; direction only picks the read source
    serial_iface_enable <= 1'b1;
    wr(ER, 8'h00, OK);
    repeat (6) @(posedge aclk);
    check("port_e_oe_n", port_e_oe_n, 2'h2);
    check("tx_pin", port_e_out[0], 1'b0);
    check("serial_rx", serial_rx, 1'b1);
    rdc(ED, 8'h02, OK);
    // Transmit pin with direction set to output; serial_tx and latch bit 0 are both 1 here
    serial_tx <= 1'b1;
    wr(ER, 8'h03, OK);
    rdc(ED, 8'h01, OK);
    check("tx_pin", port_e_out[0], 1'b1);
    serial_iface_enable <= 1'b0;
    repeat (2) @(posedge aclk);
    check("port_e", {port_e_oe_n, port_e_out}, 4'h1);
    $display("test port e done");
  endtask : t_port_e
  // Second reset mid-run: directions clear, latches survive
  task automatic t_keep;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(ER, 8'h00, OK);
    wr(CR, 8'h1f, OK);
    wr(DR, 8'h03, OK);
    wr(ER, 8'h03, OK);
    rdc(CD, 8'h1b, OK);
    rdc(DD, 8'h02, OK);
    rdc(ED, 8'h01, OK);
    $display("test keep done");
  endtask : t_keep
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  // Main sequence: 12-cycle reset, then the scenarios
  initial
  begin
    aclk = 1'b0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr} = '0;
    {araddr, wdata, wstrb, edge_level_select, timer_channel_out} = '0;
    {timer_channel_oe, serial_iface_enable, serial_tx, ext_c} = '0;
    {ext_d, ext_e, n_errors, samples_checked} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_port_c;
    t_port_d;
    t_port_e;
    t_keep;
    finish_test;
  end
  // Watchdog: far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    finish_test;
  end
endmodule : gpio_ports_c_d_e_bench
bind gpio_ports_c_d_e gpio_ports_c_d_e_props props (.*);
